/* File: acl_consts.svh */
// Register offsets, field positions, reset values and protocol codes of the entry
`ifndef ACL_CONSTS_SVH
`define ACL_CONSTS_SVH

`define ACL_OFF_CTRL 8'h00
`define ACL_OFF_DST_MODE 8'h04
`define ACL_OFF_DST_ADDR 8'h08
`define ACL_OFF_DST_MASK 8'h0c
`define ACL_OFF_V6_CFG 8'h10
`define ACL_OFF_SIP6_ADDR 8'h14
`define ACL_OFF_SIP6_MASK 8'h18
`define ACL_OFF_ICMP 8'h1c
`define ACL_OFF_STATUS 8'h20
`define ACL_OFF_HIT_CNT 8'h24

`define ACL_WMASK_CTRL 32'h0000_0003
`define ACL_WMASK_DST_MODE 32'h0000_0003
`define ACL_WMASK_V6_CFG 32'h0007_ff07
`define ACL_WMASK_ICMP 32'hff01_ff01
`define ACL_WMASK_ALL 32'hffff_ffff

`define ACL_RST_WORD 32'h0000_0000

`define ACL_CTRL_FT_LSB 0
`define ACL_V6_NH_MODE_LSB 0
`define ACL_V6_NH_VAL_LSB 8
`define ACL_V6_SRC_SPEC_BIT 16
`define ACL_V6_HOP_LSB 17
`define ACL_ICMP_TYPE_SPEC_BIT 0
`define ACL_ICMP_TYPE_LSB 8
`define ACL_ICMP_CODE_SPEC_BIT 16
`define ACL_ICMP_CODE_LSB 24

`define ACL_PROTO_ICMPV6 8'h3a
`define ACL_PROTO_UDP 8'h11
`define ACL_PROTO_TCP 8'h06

`define ACL_RESP_OKAY 2'h0
`define ACL_RESP_SLVERR 2'h2

`endif

/* File: acl_pkg.sv */
// Types shared by the access control entry design
package acl_pkg;

  typedef enum logic [1:0] {ACL_FT_ANY, ACL_FT_IPV4, ACL_FT_IPV6} acl_frame_sel_type;
  typedef enum logic [1:0] {ACL_DST_ANY, ACL_DST_HOST, ACL_DST_NET} acl_dst_mode_type;
  typedef enum logic [2:0] {
    ACL_NH_ANY, ACL_NH_SPECIFIC, ACL_NH_ICMP, ACL_NH_UDP, ACL_NH_TCP
  } acl_nh_mode_type;
  typedef enum logic [1:0] {ACL_HOP_ANY, ACL_HOP_ZERO, ACL_HOP_NONZERO} acl_hop_mode_type;

  typedef struct packed {
    logic aw_held;
    logic w_held;
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic wr_en;
    logic [31:0] wdata;
    logic [3:0] wstrb;
  } acl_axil_state_type;

endpackage

/* File: acl_axil_slave.sv */
// AXI4-Lite slave front end: one write and one read in flight
`timescale 1ns/10ps
`include "acl_consts.svh"

module acl_axil_slave import acl_pkg::*; #(
  parameter int ADDR_W = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic [31:0] i_rd_data,
  input wire logic i_rd_ok,
  input wire logic i_wr_ok,
  output logic [ADDR_W-1:0] o_wr_addr,
  output logic [31:0] o_wr_data,
  output logic [3:0] o_wr_strb,
  output logic o_wr_en
);

  acl_axil_state_type state_ff;
  acl_axil_state_type nxt_state;
  logic [ADDR_W-1:0] waddr_ff;
  logic [ADDR_W-1:0] nxt_waddr;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_state = state_ff;
    nxt_waddr = waddr_ff;
    nxt_state.wr_en = 1'b0;
    if (i_awvalid && state_ff.awready) begin
      nxt_state.aw_held = 1'b1;
      nxt_waddr = i_awaddr;
    end
    if (i_wvalid && state_ff.wready) begin
      nxt_state.w_held = 1'b1;
      nxt_state.wdata = i_wdata;
      nxt_state.wstrb = i_wstrb;
    end
    // Address and data may arrive in either order
    if (state_ff.aw_held && state_ff.w_held && !state_ff.bvalid) begin
      nxt_state.wr_en = 1'b1;
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp = i_wr_ok ? `ACL_RESP_OKAY : `ACL_RESP_SLVERR;
      nxt_state.aw_held = 1'b0;
      nxt_state.w_held = 1'b0;
    end
    if (state_ff.bvalid && i_bready) begin
      nxt_state.bvalid = 1'b0;
    end
    if (i_arvalid && state_ff.arready) begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rdata = i_rd_data;
      nxt_state.rresp = i_rd_ok ? `ACL_RESP_OKAY : `ACL_RESP_SLVERR;
    end else if (state_ff.rvalid && i_rready) begin
      nxt_state.rvalid = 1'b0;
    end
    // Ready is registered, so it drops while a transfer is pending
    nxt_state.awready = !nxt_state.aw_held && !nxt_state.bvalid;
    nxt_state.wready = !nxt_state.w_held && !nxt_state.bvalid;
    nxt_state.arready = !nxt_state.rvalid;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= '0;
      waddr_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      waddr_ff <= nxt_waddr;
    end
  end

  assign o_awready = state_ff.awready;
  assign o_wready = state_ff.wready;
  assign o_arready = state_ff.arready;
  assign o_bvalid = state_ff.bvalid;
  assign o_bresp = state_ff.bresp;
  assign o_rvalid = state_ff.rvalid;
  assign o_rresp = state_ff.rresp;
  assign o_rdata = state_ff.rdata;
  assign o_wr_en = state_ff.wr_en;
  assign o_wr_addr = waddr_ff;
  assign o_wr_data = state_ff.wdata;
  assign o_wr_strb = state_ff.wstrb;

endmodule // acl_axil_slave

/* File: acl_match.sv */
// Combinational criterion compare for one access control entry
`timescale 1ns/10ps
`include "acl_consts.svh"

module acl_match import acl_pkg::*; (
  input wire logic [1:0] i_frame_sel,
  input wire logic [1:0] i_dst_mode,
  input wire logic [31:0] i_dst_addr,
  input wire logic [31:0] i_dst_mask,
  input wire logic [2:0] i_nh_mode,
  input wire logic [7:0] i_nh_value,
  input wire logic i_src_spec,
  input wire logic [31:0] i_src_addr,
  input wire logic [31:0] i_src_mask,
  input wire logic [1:0] i_hop_mode,
  input wire logic i_type_spec,
  input wire logic [7:0] i_type_value,
  input wire logic i_code_spec,
  input wire logic [7:0] i_code_value,
  input wire logic i_is_ipv4,
  input wire logic i_is_ipv6,
  input wire logic i_has_icmp,
  input wire logic [31:0] i_dst_ip,
  input wire logic [7:0] i_next_header,
  input wire logic [31:0] i_src_v6_low,
  input wire logic [7:0] i_hop_limit,
  input wire logic [7:0] i_icmp_type,
  input wire logic [7:0] i_icmp_code,
  output logic o_match
);

  logic ft_ok;
  logic dst_ok;
  logic nh_ok;
  logic src_ok;
  logic hop_ok;
  logic icmp_ok;
  logic v6_ok;

  always_comb begin
    unique case (i_frame_sel)
      ACL_FT_ANY: ft_ok = 1'b1;
      ACL_FT_IPV4: ft_ok = i_is_ipv4;
      ACL_FT_IPV6: ft_ok = i_is_ipv6;
      default: ft_ok = 1'b0;
    endcase
    unique case (i_dst_mode)
      ACL_DST_ANY: dst_ok = 1'b1;
      ACL_DST_HOST: dst_ok = (i_dst_ip == i_dst_addr);
      ACL_DST_NET: dst_ok = ((i_dst_ip & i_dst_mask) == (i_dst_addr & i_dst_mask));
      default: dst_ok = 1'b0;
    endcase
    unique case (i_nh_mode)
      ACL_NH_ANY: nh_ok = 1'b1;
      ACL_NH_SPECIFIC: nh_ok = (i_next_header == i_nh_value);
      ACL_NH_ICMP: nh_ok = (i_next_header == `ACL_PROTO_ICMPV6);
      ACL_NH_UDP: nh_ok = (i_next_header == `ACL_PROTO_UDP);
      ACL_NH_TCP: nh_ok = (i_next_header == `ACL_PROTO_TCP);
      default: nh_ok = 1'b0;
    endcase
    // Only the low word of the source address is ever compared
    src_ok = !i_src_spec
      || ((i_src_v6_low & i_src_mask) == (i_src_addr & i_src_mask));
    unique case (i_hop_mode)
      ACL_HOP_ANY: hop_ok = 1'b1;
      ACL_HOP_ZERO: hop_ok = (i_hop_limit == 8'h00);
      ACL_HOP_NONZERO: hop_ok = (i_hop_limit != 8'h00);
      default: hop_ok = 1'b0;
    endcase
    // A frame with no ICMP header fails any specific ICMP test
    icmp_ok = (!i_type_spec || (i_has_icmp && i_icmp_type == i_type_value))
      && (!i_code_spec || (i_has_icmp && i_icmp_code == i_code_value));
    // IPv4 and IPv6 criteria apply only under their own frame type
    v6_ok = (i_frame_sel != ACL_FT_IPV6) || (nh_ok && src_ok && hop_ok);
    o_match = ft_ok && v6_ok && icmp_ok
      && ((i_frame_sel != ACL_FT_IPV4) || dst_ok);
  end

endmodule // acl_match

/* File: acl_entry_top.sv */
// Access control entry: register file, criterion match and hit output
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "acl_consts.svh"

module acl_entry_top import acl_pkg::*; #(
  parameter int ADDR_W = 8
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [ADDR_W-1:0] i_s_axil_awaddr,
  input wire logic i_s_axil_awvalid,
  output logic o_s_axil_awready,
  input wire logic [31:0] i_s_axil_wdata,
  input wire logic [3:0] i_s_axil_wstrb,
  input wire logic i_s_axil_wvalid,
  output logic o_s_axil_wready,
  output logic [1:0] o_s_axil_bresp,
  output logic o_s_axil_bvalid,
  input wire logic i_s_axil_bready,
  input wire logic [ADDR_W-1:0] i_s_axil_araddr,
  input wire logic i_s_axil_arvalid,
  output logic o_s_axil_arready,
  output logic [31:0] o_s_axil_rdata,
  output logic [1:0] o_s_axil_rresp,
  output logic o_s_axil_rvalid,
  input wire logic i_s_axil_rready,
  input wire logic i_hdr_valid,
  input wire logic i_is_ipv4,
  input wire logic i_is_ipv6,
  input wire logic i_has_icmp,
  input wire logic [31:0] i_dst_ip,
  input wire logic [7:0] i_next_header,
  input wire logic [31:0] i_src_v6_low,
  input wire logic [7:0] i_hop_limit,
  input wire logic [7:0] i_icmp_type,
  input wire logic [7:0] i_icmp_code,
  output logic o_hit,
  output logic o_hit_valid
);

  if (ADDR_W < 8 || ADDR_W > 32) begin : g_addr_check
    $error("ADDR_W must lie between 8 and 32");
  end

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] dst_mode;
    logic [31:0] dst_addr;
    logic [31:0] dst_mask;
    logic [31:0] v6_cfg;
    logic [31:0] src_addr;
    logic [31:0] src_mask;
    logic [31:0] icmp;
    logic [31:0] hit_cnt;
    logic hit;
    logic hit_valid;
  } acl_top_state_type;

  acl_top_state_type state_ff;
  acl_top_state_type nxt_state;
  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic rd_ok;
  logic [31:0] rd_data;
  logic match;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops to avoid a metastable release edge
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb, input logic [31:0] wmask);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res & wmask;
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return a == ADDR_W'(`ACL_OFF_CTRL) || a == ADDR_W'(`ACL_OFF_DST_MODE)
      || a == ADDR_W'(`ACL_OFF_DST_ADDR) || a == ADDR_W'(`ACL_OFF_DST_MASK)
      || a == ADDR_W'(`ACL_OFF_V6_CFG) || a == ADDR_W'(`ACL_OFF_SIP6_ADDR)
      || a == ADDR_W'(`ACL_OFF_SIP6_MASK) || a == ADDR_W'(`ACL_OFF_ICMP)
      || a == ADDR_W'(`ACL_OFF_STATUS) || a == ADDR_W'(`ACL_OFF_HIT_CNT);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  acl_axil_slave #(
    .ADDR_W(ADDR_W)
  ) acl_axil_slave_inst (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_awaddr(i_s_axil_awaddr),
    .i_awvalid(i_s_axil_awvalid),
    .o_awready(o_s_axil_awready),
    .i_wdata(i_s_axil_wdata),
    .i_wstrb(i_s_axil_wstrb),
    .i_wvalid(i_s_axil_wvalid),
    .o_wready(o_s_axil_wready),
    .o_bresp(o_s_axil_bresp),
    .o_bvalid(o_s_axil_bvalid),
    .i_bready(i_s_axil_bready),
    .i_arvalid(i_s_axil_arvalid),
    .o_arready(o_s_axil_arready),
    .o_rdata(o_s_axil_rdata),
    .o_rresp(o_s_axil_rresp),
    .o_rvalid(o_s_axil_rvalid),
    .i_rready(i_s_axil_rready),
    .i_rd_data(rd_data),
    .i_rd_ok(rd_ok),
    .i_wr_ok(wr_ok),
    .o_wr_addr(wr_addr),
    .o_wr_data(wr_data),
    .o_wr_strb(wr_strb),
    .o_wr_en(wr_en)
  );

  // Status is read-only and a write to hit count clears it; both writes are accepted
  assign wr_ok = is_mapped(wr_addr);
  assign rd_ok = is_mapped(i_s_axil_araddr);

  always_comb begin
    unique case (i_s_axil_araddr)
      ADDR_W'(`ACL_OFF_CTRL): rd_data = state_ff.ctrl;
      ADDR_W'(`ACL_OFF_DST_MODE): rd_data = state_ff.dst_mode;
      ADDR_W'(`ACL_OFF_DST_ADDR): rd_data = state_ff.dst_addr;
      ADDR_W'(`ACL_OFF_DST_MASK): rd_data = state_ff.dst_mask;
      ADDR_W'(`ACL_OFF_V6_CFG): rd_data = state_ff.v6_cfg;
      ADDR_W'(`ACL_OFF_SIP6_ADDR): rd_data = state_ff.src_addr;
      ADDR_W'(`ACL_OFF_SIP6_MASK): rd_data = state_ff.src_mask;
      ADDR_W'(`ACL_OFF_ICMP): rd_data = state_ff.icmp;
      ADDR_W'(`ACL_OFF_STATUS): rd_data = {30'h0, state_ff.hit_valid, state_ff.hit};
      ADDR_W'(`ACL_OFF_HIT_CNT): rd_data = state_ff.hit_cnt;
      default: rd_data = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  acl_match acl_match_inst (
    .i_frame_sel(state_ff.ctrl[`ACL_CTRL_FT_LSB +: 2]),
    .i_dst_mode(state_ff.dst_mode[1:0]),
    .i_dst_addr(state_ff.dst_addr),
    .i_dst_mask(state_ff.dst_mask),
    .i_nh_mode(state_ff.v6_cfg[`ACL_V6_NH_MODE_LSB +: 3]),
    .i_nh_value(state_ff.v6_cfg[`ACL_V6_NH_VAL_LSB +: 8]),
    .i_src_spec(state_ff.v6_cfg[`ACL_V6_SRC_SPEC_BIT]),
    .i_src_addr(state_ff.src_addr),
    .i_src_mask(state_ff.src_mask),
    .i_hop_mode(state_ff.v6_cfg[`ACL_V6_HOP_LSB +: 2]),
    .i_type_spec(state_ff.icmp[`ACL_ICMP_TYPE_SPEC_BIT]),
    .i_type_value(state_ff.icmp[`ACL_ICMP_TYPE_LSB +: 8]),
    .i_code_spec(state_ff.icmp[`ACL_ICMP_CODE_SPEC_BIT]),
    .i_code_value(state_ff.icmp[`ACL_ICMP_CODE_LSB +: 8]),
    .i_is_ipv4(i_is_ipv4),
    .i_is_ipv6(i_is_ipv6),
    .i_has_icmp(i_has_icmp),
    .i_dst_ip(i_dst_ip),
    .i_next_header(i_next_header),
    .i_src_v6_low(i_src_v6_low),
    .i_hop_limit(i_hop_limit),
    .i_icmp_type(i_icmp_type),
    .i_icmp_code(i_icmp_code),
    .o_match(match)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_state = state_ff;
    if (wr_en) begin
      unique case (wr_addr)
        ADDR_W'(`ACL_OFF_CTRL):
          nxt_state.ctrl = merge(state_ff.ctrl, wr_data, wr_strb, `ACL_WMASK_CTRL);
        ADDR_W'(`ACL_OFF_DST_MODE):
          nxt_state.dst_mode = merge(state_ff.dst_mode, wr_data, wr_strb, `ACL_WMASK_DST_MODE);
        ADDR_W'(`ACL_OFF_DST_ADDR):
          nxt_state.dst_addr = merge(state_ff.dst_addr, wr_data, wr_strb, `ACL_WMASK_ALL);
        ADDR_W'(`ACL_OFF_DST_MASK):
          nxt_state.dst_mask = merge(state_ff.dst_mask, wr_data, wr_strb, `ACL_WMASK_ALL);
        ADDR_W'(`ACL_OFF_V6_CFG):
          nxt_state.v6_cfg = merge(state_ff.v6_cfg, wr_data, wr_strb, `ACL_WMASK_V6_CFG);
        ADDR_W'(`ACL_OFF_SIP6_ADDR):
          nxt_state.src_addr = merge(state_ff.src_addr, wr_data, wr_strb, `ACL_WMASK_ALL);
        ADDR_W'(`ACL_OFF_SIP6_MASK):
          nxt_state.src_mask = merge(state_ff.src_mask, wr_data, wr_strb, `ACL_WMASK_ALL);
        ADDR_W'(`ACL_OFF_ICMP):
          nxt_state.icmp = merge(state_ff.icmp, wr_data, wr_strb, `ACL_WMASK_ICMP);
        ADDR_W'(`ACL_OFF_HIT_CNT):
          nxt_state.hit_cnt = 32'h0;
        default: ;
      endcase
    end
    // One clock from header valid to result
    nxt_state.hit_valid = i_hdr_valid;
    nxt_state.hit = i_hdr_valid && match;
    // A hit in the clearing cycle still counts; the count wraps after 2^32 hits
    if (i_hdr_valid && match) begin
      nxt_state.hit_cnt = nxt_state.hit_cnt + 32'h1;
    end
  end

  // Reset leaves every criterion at any
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_hit = state_ff.hit;
  assign o_hit_valid = state_ff.hit_valid;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!rst_n);

  a_hit_latency: assert property (i_hdr_valid
      |=> o_hit_valid ##1 (o_hit_valid == $past(i_hdr_valid)))
    else $error("hit valid not one clock after header valid");
  a_hit_needs_valid: assert property (o_hit |-> o_hit_valid)
    else $error("hit without valid");
  a_dst_host: assert property (i_hdr_valid && state_ff.ctrl[1:0] == ACL_FT_IPV4
      && state_ff.dst_mode[1:0] == ACL_DST_HOST && i_dst_ip != state_ff.dst_addr |=> !o_hit)
    else $error("host destination mismatch gave a hit");
  a_dst_network: assert property (i_hdr_valid && state_ff.ctrl[1:0] == ACL_FT_IPV4
      && state_ff.dst_mode[1:0] == ACL_DST_NET
      && ((i_dst_ip ^ state_ff.dst_addr) & state_ff.dst_mask) != 32'h0 |=> !o_hit)
    else $error("network destination mismatch gave a hit");
  a_v4_only: assert property (i_hdr_valid && state_ff.ctrl[1:0] == ACL_FT_IPV4
      && !i_is_ipv4 |=> o_hit_valid && !o_hit)
    else $error("non-IPv4 frame hit an IPv4 entry");
  a_v6_only: assert property (i_hdr_valid && state_ff.ctrl[1:0] == ACL_FT_IPV6
      && !i_is_ipv6 |=> o_hit_valid && !o_hit)
    else $error("non-IPv6 frame hit an IPv6 entry");
  a_nh_value: assert property (i_hdr_valid && state_ff.ctrl[1:0] == ACL_FT_IPV6
      && state_ff.v6_cfg[2:0] == ACL_NH_SPECIFIC && i_next_header != state_ff.v6_cfg[15:8]
      |=> !o_hit)
    else $error("next header mismatch gave a hit");
  a_nh_udp: assert property (i_hdr_valid && state_ff.ctrl[1:0] == ACL_FT_IPV6
      && state_ff.v6_cfg[2:0] == ACL_NH_UDP && i_next_header != `ACL_PROTO_UDP |=> !o_hit)
    else $error("non-UDP next header hit a UDP entry");
  a_src_masked: assert property (i_hdr_valid && state_ff.ctrl[1:0] == ACL_FT_IPV6
      && state_ff.v6_cfg[16]
      && ((i_src_v6_low ^ state_ff.src_addr) & state_ff.src_mask) != 32'h0 |=> !o_hit)
    else $error("masked source mismatch gave a hit");
  a_hop_zero: assert property (i_hdr_valid && state_ff.ctrl[1:0] == ACL_FT_IPV6
      && state_ff.v6_cfg[18:17] == ACL_HOP_ZERO && i_hop_limit != 8'h00 |=> !o_hit)
    else $error("hop limit above zero hit a zero entry");
  a_hop_nonzero: assert property (i_hdr_valid && state_ff.ctrl[1:0] == ACL_FT_IPV6
      && state_ff.v6_cfg[18:17] == ACL_HOP_NONZERO && i_hop_limit == 8'h00 |=> !o_hit)
    else $error("zero hop limit hit a non-zero entry");
  a_icmp_type: assert property (i_hdr_valid && state_ff.icmp[0]
      && (!i_has_icmp || i_icmp_type != state_ff.icmp[15:8]) |=> !o_hit)
    else $error("ICMP type mismatch gave a hit");
  a_icmp_code: assert property (i_hdr_valid && state_ff.icmp[16]
      && (!i_has_icmp || i_icmp_code != state_ff.icmp[31:24]) |=> !o_hit)
    else $error("ICMP code mismatch gave a hit");
  a_all_any: assert property (i_hdr_valid && state_ff.ctrl[1:0] == ACL_FT_ANY
      && state_ff.icmp[0] == 1'b0 && state_ff.icmp[16] == 1'b0 |=> o_hit)
    else $error("entry with all criteria any did not hit");
  a_dst_any: assert property (i_hdr_valid && state_ff.ctrl[1:0] == ACL_FT_IPV4
      && i_is_ipv4 && state_ff.dst_mode[1:0] == ACL_DST_ANY
      && state_ff.icmp == 32'h0 |=> o_hit)
    else $error("IPv4 entry with destination any did not hit");
  a_type_never: assert property (i_hdr_valid && state_ff.ctrl[1:0] == 2'h3 |=> !o_hit)
    else $error("entry with unused frame type gave a hit");
  a_reset_any: assert property ($rose(rst_n) |-> state_ff.ctrl == 32'h0
      && state_ff.v6_cfg == 32'h0 && state_ff.icmp == 32'h0)
    else $error("criteria not any after reset");

endmodule // acl_entry_top

/* File: acl_hdr_src.sv */
// Frame header parser model: one parsed header set per call
`timescale 1ns/10ps
module acl_hdr_src (
  input wire logic i_clk,
  output logic o_hdr_valid,
  output logic o_is_ipv4,
  output logic o_is_ipv6,
  output logic o_has_icmp,
  output logic [31:0] o_dst_ip,
  output logic [7:0] o_next_header,
  output logic [31:0] o_src_v6_low,
  output logic [7:0] o_hop_limit,
  output logic [7:0] o_icmp_type,
  output logic [7:0] o_icmp_code
);
  initial begin
    o_hdr_valid = 1'b0;
    {o_is_ipv4, o_is_ipv6, o_has_icmp, o_dst_ip, o_src_v6_low} = '0;
    {o_next_header, o_hop_limit, o_icmp_type, o_icmp_code} = '0;
  end
  // Fields flip outside the valid cycle so a late sample shows up as a miss
  task automatic send(input logic [1:0] ft, input logic ic, input logic [31:0] a,
                      input logic [7:0] b, input logic [7:0] c);
    @(posedge i_clk);
    o_hdr_valid <= 1'b1;
    {o_is_ipv4, o_is_ipv6, o_has_icmp} <= {ft[0], ft[1], ic};
    {o_dst_ip, o_src_v6_low} <= {a, a};
    {o_next_header, o_hop_limit, o_icmp_type, o_icmp_code} <= {b, b, b, c};
    @(posedge i_clk);
    o_hdr_valid <= 1'b0;
    {o_is_ipv4, o_is_ipv6, o_has_icmp} <= ~{ft[0], ft[1], ic};
    {o_dst_ip, o_src_v6_low} <= ~{a, a};
    {o_next_header, o_hop_limit, o_icmp_type, o_icmp_code} <= ~{b, b, b, c};
  endtask
endmodule // acl_hdr_src

/* File: acl_entry_ip_icmp_matcher_tb.sv */
// Self-checking bench of the access control entry
`timescale 1ns/10ps
`include "acl_consts.svh"
module acl_entry_ip_icmp_matcher_tb;
  logic i_clk, i_reset_n = 1'b0;
  logic [7:0] i_s_axil_awaddr = 8'h00, i_s_axil_araddr = 8'h00;
  logic [31:0] i_s_axil_wdata = 32'h0;
  logic [3:0] i_s_axil_wstrb = 4'h0;
  logic i_s_axil_awvalid = 1'b0, i_s_axil_wvalid = 1'b0, i_s_axil_bready = 1'b0;
  logic i_s_axil_arvalid = 1'b0, i_s_axil_rready = 1'b0;
  logic o_s_axil_awready, o_s_axil_wready, o_s_axil_bvalid, o_s_axil_arready;
  logic o_s_axil_rvalid, o_hit, o_hit_valid;
  logic [1:0] o_s_axil_bresp, o_s_axil_rresp;
  logic [31:0] o_s_axil_rdata;
  logic i_hdr_valid, i_is_ipv4, i_is_ipv6, i_has_icmp;
  logic [31:0] i_dst_ip, i_src_v6_low;
  logic [7:0] i_next_header, i_hop_limit, i_icmp_type, i_icmp_code;
  int error_cnt = 0, checks = 0;
  logic [31:0] nh_cfg [8] = '{32'hff01, 32'hff01, 32'h2, 32'h2, 32'h3, 32'h3, 32'h4, 32'h4};
  logic [7:0] nh_frm [8] = '{8'hff, 8'hfe, 8'h3a, 8'h11, 8'h11, 8'h06, 8'h06, 8'h3a};
  logic [7:0] nh_exp = 8'h55;
  int hits = 0;

  acl_entry_top acl_entry_top_inst (.*);
  acl_hdr_src acl_hdr_src_inst (.i_clk(i_clk), .o_hdr_valid(i_hdr_valid),
    .o_is_ipv4(i_is_ipv4), .o_is_ipv6(i_is_ipv6), .o_has_icmp(i_has_icmp),
    .o_dst_ip(i_dst_ip), .o_next_header(i_next_header), .o_src_v6_low(i_src_v6_low),
    .o_hop_limit(i_hop_limit), .o_icmp_type(i_icmp_type), .o_icmp_code(i_icmp_code));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    if (error_cnt == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Both channels offered together, each released at its own handshake
  task automatic wrc(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er = `ACL_RESP_OKAY);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge i_clk);
    i_s_axil_awaddr <= a;
    i_s_axil_awvalid <= 1'b1;
    i_s_axil_wdata <= d;
    i_s_axil_wstrb <= 4'hf;
    i_s_axil_wvalid <= 1'b1;
    i_s_axil_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge i_clk);
      if (o_s_axil_awready && !ad) begin
        ad = 1'b1;
        i_s_axil_awvalid <= 1'b0;
      end
      if (o_s_axil_wready && !wd) begin
        wd = 1'b1;
        i_s_axil_wvalid <= 1'b0;
      end
    end
    do @(posedge i_clk); while (o_s_axil_bvalid !== 1'b1);
    i_s_axil_bready <= 1'b0;
    chk({30'h0, o_s_axil_bresp}, {30'h0, er});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge i_clk);
    i_s_axil_araddr <= a;
    i_s_axil_arvalid <= 1'b1;
    i_s_axil_rready <= 1'b1;
    do @(posedge i_clk); while (o_s_axil_arready !== 1'b1);
    i_s_axil_arvalid <= 1'b0;
    do @(posedge i_clk); while (o_s_axil_rvalid !== 1'b1);
    i_s_axil_rready <= 1'b0;
    chk(o_s_axil_rdata, e);
    chk({30'h0, o_s_axil_rresp}, {30'h0, er});
  endtask

  // Result is looked at in the one cycle that it stands
  task automatic hd(input logic [1:0] ft, input logic ic, input logic [31:0] a,
                    input logic [7:0] b, input logic [7:0] c, input logic e);
    acl_hdr_src_inst.send(ft, ic, a, b, c);
    #1;
    chk({31'h0, o_hit_valid}, 32'h1);
    chk({31'h0, o_hit}, {31'h0, e});
    if (e) begin
      hits++;
    end
  endtask

  initial begin
    #100000;
    error_cnt++;
    stop_test;
  end

  initial begin
    repeat (5) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    rdc(`ACL_OFF_V6_CFG, 32'h0, `ACL_RESP_OKAY);
    rdc(`ACL_OFF_ICMP, 32'h0, `ACL_RESP_OKAY);
    rdc(8'h40, 32'h0, `ACL_RESP_SLVERR);
    wrc(8'h40, 32'hffff_ffff, `ACL_RESP_SLVERR);
    hd(2'h1, 1'b0, 32'h1234_5678, 8'h00, 8'h00, 1'b1);
    wrc(`ACL_OFF_ICMP, 32'heeff_ffff);
    rdc(`ACL_OFF_ICMP, 32'hee01_ff01, `ACL_RESP_OKAY);
    wrc(`ACL_OFF_ICMP, 32'h0001_ff01);
    hd(2'h0, 1'b1, 32'h0, 8'hff, 8'h00, 1'b1);
    hd(2'h0, 1'b1, 32'h0, 8'hfe, 8'h00, 1'b0);
    hd(2'h0, 1'b1, 32'h0, 8'hff, 8'h01, 1'b0);
    hd(2'h0, 1'b0, 32'h0, 8'hff, 8'h00, 1'b0);
    wrc(`ACL_OFF_ICMP, 32'h0);
    wrc(`ACL_OFF_CTRL, 32'h1);
    wrc(`ACL_OFF_DST_MODE, 32'h1);
    wrc(`ACL_OFF_DST_ADDR, 32'hc0a8_0001);
    wrc(`ACL_OFF_DST_MASK, 32'hffff_ff00);
    hd(2'h1, 1'b0, 32'hc0a8_0001, 8'h00, 8'h00, 1'b1);
    hd(2'h1, 1'b0, 32'hc0a8_0000, 8'h00, 8'h00, 1'b0);
    hd(2'h2, 1'b0, 32'hc0a8_0001, 8'h00, 8'h00, 1'b0);
    wrc(`ACL_OFF_DST_MODE, 32'h2);
    hd(2'h1, 1'b0, 32'hc0a8_00ee, 8'h00, 8'h00, 1'b1);
    hd(2'h1, 1'b0, 32'hc0a8_01ee, 8'h00, 8'h00, 1'b0);
    wrc(`ACL_OFF_DST_MODE, 32'h0);
    hd(2'h1, 1'b0, 32'h0a00_0001, 8'h00, 8'h00, 1'b1);
    wrc(`ACL_OFF_CTRL, 32'h2);
    hd(2'h1, 1'b0, 32'h0, 8'h00, 8'h00, 1'b0);
    for (int i = 0; i < 8; i++) begin
      wrc(`ACL_OFF_V6_CFG, nh_cfg[i]);
      hd(2'h2, 1'b0, 32'h0, nh_frm[i], 8'h00, nh_exp[i]);
    end
    wrc(`ACL_OFF_SIP6_ADDR, 32'h3);
    wrc(`ACL_OFF_SIP6_MASK, 32'hffff_fffe);
    wrc(`ACL_OFF_V6_CFG, 32'h0001_0000);
    hd(2'h2, 1'b0, 32'h2, 8'h00, 8'h00, 1'b1);
    hd(2'h2, 1'b0, 32'h3, 8'h00, 8'h00, 1'b1);
    hd(2'h2, 1'b0, 32'h1, 8'h00, 8'h00, 1'b0);
    wrc(`ACL_OFF_V6_CFG, 32'h0);
    hd(2'h2, 1'b0, 32'h1, 8'h00, 8'h00, 1'b1);
    wrc(`ACL_OFF_V6_CFG, 32'h0002_0000);
    hd(2'h2, 1'b0, 32'h0, 8'h00, 8'h00, 1'b1);
    hd(2'h2, 1'b0, 32'h0, 8'h01, 8'h00, 1'b0);
    wrc(`ACL_OFF_V6_CFG, 32'h0004_0000);
    hd(2'h2, 1'b0, 32'h0, 8'h00, 8'h00, 1'b0);
    hd(2'h2, 1'b0, 32'h0, 8'h05, 8'h00, 1'b1);
    wrc(`ACL_OFF_CTRL, 32'h3);
    hd(2'h2, 1'b0, 32'h0, 8'h05, 8'h00, 1'b0);
    rdc(`ACL_OFF_STATUS, 32'h0, `ACL_RESP_OKAY);
    rdc(`ACL_OFF_HIT_CNT, hits, `ACL_RESP_OKAY);
    wrc(`ACL_OFF_HIT_CNT, 32'h0);
    rdc(`ACL_OFF_HIT_CNT, 32'h0, `ACL_RESP_OKAY);
    stop_test;
  end
endmodule // acl_entry_ip_icmp_matcher_tb
